// ===== test/ohci_cmd_irq_chk.sv
// Purpose: Port-level checks of the command and event-flag block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound into every instance of the top module
`timescale 1ns/10ps
module ohci_cmd_irq_chk (
  input wire logic ref_clk_in, // Clock
  input wire logic rstn_in, // Async reset, low
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  input wire logic reg_ack_out, // Access answered
  input wire logic bulk_start_in, // Bulk list head
  input wire logic bulk_go_out, // Bulk list go
  input wire logic done_wr_in, // Done head written
  input wire logic done_hold_out, // Done writes held
  input wire logic fatal_err_in, // System error
  input wire logic halt_out, // Processing halted
  input wire logic sw_reset_out, // Software reset running
  input wire logic [1:0] func_state_out, // State override
  input wire logic func_state_ld_out, // State load
  input wire logic irq_out, // Host interrupt
  input wire logic system_mgmt_irq_pin_out // Management interrupt
);
  import ohci_cmd_pkg::*;
  logic [10:0] rst_len_ff;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);
  // ----------------------------------------
  // Software reset length counter
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_len_ff <= 11'h000;
    end else if (sw_reset_out) begin
      rst_len_ff <= rst_len_ff + 11'h001;
    end else begin
      rst_len_ff <= 11'h000;
    end
  end
  chk_ack_has_cause: assert property (
    reg_ack_out |-> $past(reg_wr_in || reg_rd_in))
    else $error("ack without a request");
  chk_reset_blocks_bus: assert property (
    sw_reset_out && $past(sw_reset_out) |-> !reg_ack_out)
    else $error("ack during software reset");
  chk_reset_length: assert property (
    $fell(sw_reset_out) |-> rst_len_ff == 11'(RESET_CYCLES))
    else $error("software reset length wrong");
  chk_suspend_load: assert property (
    func_state_ld_out |-> func_state_out == SUSPENDED_STATE)
    else $error("load without suspended state");
  chk_bulk_go_cause: assert property (
    $rose(bulk_go_out) |-> $past(bulk_start_in))
    else $error("bulk go without list start");
  chk_done_hold_set: assert property (
    done_wr_in |=> done_hold_out)
    else $error("done writes not held");
  chk_halt_on_error: assert property (
    fatal_err_in && !sw_reset_out |=> halt_out)
    else $error("no halt after system error");
  chk_halt_kept: assert property (
    halt_out && !sw_reset_out |=> halt_out || sw_reset_out)
    else $error("halt dropped without reset");
  cov_reset_done: cover property ($fell(sw_reset_out));
  cov_irq: cover property ($rose(irq_out));
  cov_smi: cover property ($rose(system_mgmt_irq_pin_out));
endmodule
bind ohci_cmd_irq ohci_cmd_irq_chk chk_u (.ref_clk_in(ref_clk_in),
  .rstn_in(rstn_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_ack_out(reg_ack_out), .bulk_start_in(bulk_start_in),
  .bulk_go_out(bulk_go_out), .done_wr_in(done_wr_in),
  .done_hold_out(done_hold_out), .fatal_err_in(fatal_err_in),
  .halt_out(halt_out), .sw_reset_out(sw_reset_out),
  .func_state_out(func_state_out), .func_state_ld_out(func_state_ld_out),
  .irq_out(irq_out), .system_mgmt_irq_pin_out(system_mgmt_irq_pin_out));

// ===== test/ohci_sw_host.sv
// Purpose: Driver-software model issuing register port accesses
// Assumes: Strobes change at the falling edge
// Notes: Released address and data lines show the inverse value
`timescale 1ns/10ps
module ohci_sw_host (
  input wire logic ref_clk_in, // Clock
  input wire logic [31:0] reg_rdata_in, // Read data
  input wire logic reg_ack_in, // Access answered
  output logic reg_wr_out, // Write strobe
  output logic reg_rd_out, // Read strobe
  output logic [7:0] reg_addr_out, // Byte offset
  output logic [31:0] reg_wdata_out // Write data
);
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 32'h00000000;
  end
  // One-cycle strobe, answer sampled while it stands
  task automatic access(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic ok);
    @(negedge ref_clk_in);
    reg_wr_out = w;
    reg_rd_out = !w;
    reg_addr_out = a;
    reg_wdata_out = d;
    @(negedge ref_clk_in);
    ok = reg_ack_in;
    q = reg_rdata_in;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
endmodule

// ===== test/tb_top.sv
// Purpose: Sequence tests of the command and event-flag block
// Assumes: 100 MHz clock, reset held 20 cycles
// Notes: Engine events are driven at the falling edge
`timescale 1ns/10ps
module tb_top;
  import ohci_cmd_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [9:0] ev = 10'h000;
  logic bit15 = 1'b0, res_pin = 1'b0, sw_res = 1'b0, hub = 1'b0;
  logic wr, rd, ack, go_b, go_c, hold, halt, srst, ld, irq, smi;
  logic [7:0] addr;
  logic [31:0] wd, rdat;
  logic [1:0] fst;
  int bad_count = 0, n_checks = 0;
  initial forever #5 ref_clk_in = ~ref_clk_in;
  ohci_sw_host host_u (.ref_clk_in(ref_clk_in), .reg_rdata_in(rdat),
    .reg_ack_in(ack), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_addr_out(addr), .reg_wdata_out(wd));
  ohci_cmd_irq dut_u (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_rdata_out(rdat), .reg_ack_out(ack),
    .overrun_in(ev[0]), .frame_num_wr_in(ev[1]), .frame_bit15_in(bit15),
    .sof_in(ev[2]), .done_wr_in(ev[3]), .fatal_err_in(ev[4]),
    .resume_pin_in(res_pin), .sw_resume_in(sw_res), .hub_change_in(hub),
    .bulk_start_in(ev[5]), .bulk_td_in(ev[6]), .ctrl_start_in(ev[7]),
    .ctrl_td_in(ev[8]), .own_done_in(ev[9]), .bulk_go_out(go_b),
    .ctrl_go_out(go_c), .done_hold_out(hold), .halt_out(halt),
    .sw_reset_out(srst), .func_state_out(fst), .func_state_ld_out(ld),
    .irq_out(irq), .system_mgmt_irq_pin_out(smi));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic ok;
    host_u.access(1'b1, a, d, q, ok);
    chk({31'h0, ok}, 32'h1);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic ok;
    host_u.access(1'b0, a, 32'h0, q, ok);
    chk(q, e);
  endtask
  task automatic pulse(input logic [9:0] m);
    @(negedge ref_clk_in);
    ev = m;
    @(negedge ref_clk_in);
    ev = 10'h000;
    idle(3);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  logic [9:0] evm [3] = '{10'h004, 10'h008, 10'h010};
  int evb [3] = '{EV_SOF, EV_DONE, EV_FATAL};
  initial begin
    logic [31:0] q;
    logic ok;
    idle(20);
    rstn_in = 1'b1;
    foreach (evm[k]) rd_reg(CMD_OFS + 8'(4 * k), REG_RESET);
    rd_reg(8'h18, 32'h0);
    wr_reg(CMD_OFS, 32'h4);
    wr_reg(CMD_OFS, 32'h2);
    wr_reg(CMD_OFS, 32'h0);
    rd_reg(CMD_OFS, 32'h6);
    pulse(10'h020);
    chk({31'h0, go_b}, 32'h1);
    pulse(10'h020);
    chk({31'h0, go_b}, 32'h0);
    pulse(10'h040);
    pulse(10'h080);
    chk({31'h0, go_c}, 32'h1);
    rd_reg(CMD_OFS, 32'h4);
    pulse(10'h100);
    $display("command tests done");
    repeat (5) pulse(10'h003);
    rd_reg(CMD_OFS, 32'h10006);
    rd_reg(FLAGS_OFS, 32'h1);
    wr_reg(FLAGS_OFS, 32'hFFFFFFFF);
    rd_reg(FLAGS_OFS, 32'h0);
    pulse(10'h001);
    rd_reg(FLAGS_OFS, 32'h0);
    pulse(10'h002);
    rd_reg(FLAGS_OFS, 32'h1);
    wr_reg(FLAGS_OFS, 32'h1);
    foreach (evm[k]) begin
      pulse(evm[k]);
      rd_reg(FLAGS_OFS, 32'h1 << evb[k]);
      if (k == 1) chk({31'h0, hold}, 32'h1);
      wr_reg(FLAGS_OFS, 32'h1 << evb[k]);
    end
    chk({31'h0, hold}, 32'h0);
    chk({31'h0, halt}, 32'h1);
    bit15 = 1'b1;
    pulse(10'h002);
    pulse(10'h002);
    rd_reg(FLAGS_OFS, 32'h20);
    wr_reg(FLAGS_OFS, 32'h20);
    sw_res = 1'b1;
    res_pin = 1'b1;
    idle(6);
    rd_reg(FLAGS_OFS, 32'h0);
    res_pin = 1'b0;
    sw_res = 1'b0;
    idle(6);
    res_pin = 1'b1;
    hub = 1'b1;
    idle(6);
    rd_reg(FLAGS_OFS, 32'h48);
    wr_reg(FLAGS_OFS, 32'h48);
    $display("flag tests done");
    wr_reg(EN_SET_OFS, 32'h80000004);
    pulse(10'h004);
    chk({31'h0, irq}, 32'h1);
    wr_reg(EN_CLR_OFS, 32'h80000000);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    wr_reg(EN_SET_OFS, 32'hC0000000);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    wr_reg(EN_CLR_OFS, 32'h4);
    rd_reg(EN_CLR_OFS, 32'hC0000000);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    wr_reg(FLAGS_OFS, 32'h4);
    wr_reg(CMD_OFS, 32'h8);
    idle(2);
    rd_reg(CMD_OFS, 32'h2000E);
    rd_reg(FLAGS_OFS, 32'h40000000);
    chk({31'h0, smi}, 32'h1);
    pulse(10'h200);
    rd_reg(CMD_OFS, 32'h20006);
    wr_reg(FLAGS_OFS, 32'h40000000);
    idle(2);
    chk({31'h0, smi}, 32'h0);
    $display("interrupt tests done");
    wr_reg(CMD_OFS, 32'h1);
    idle(3);
    chk({30'h0, fst, ld, srst}, 32'hF);
    host_u.access(1'b0, CMD_OFS, 32'h0, q, ok);
    chk({31'h0, ok}, 32'h0);
    for (int i = 0; srst !== 1'b0; i++) begin
      if (i > 1100) begin
        bad_count++;
        $display("CHECK FAILED t=%0t software reset never ended", $time);
        end_sim();
      end
      idle(1);
    end
    rd_reg(CMD_OFS, 32'h20000);
    rd_reg(EN_SET_OFS, 32'h0);
    chk({31'h0, halt}, 32'h0);
    chk({30'h0, ld, srst}, 32'h0);
    $display("reset tests done");
    end_sim();
  end
endmodule

// ===== verilog/ohci_cmd_irq.sv
// Purpose: Command, event flag and event enable registers of one host
//   controller function, with interrupt and management-interrupt outputs
// Assumes: Simple one-cycle register port; events are same-clock strobes
//   except the hub and resume levels, which are synchronised here
// Notes: Software reset holds the port off while it runs
`timescale 1ns/10ps

module ohci_cmd_irq #(
  parameter bit HAS_SMI_PIN = 1'b1
) (
  input wire logic ref_clk_in, // 100 MHz clock
  input wire logic rstn_in, // Async reset, low
  input wire logic reg_wr_in, // Register write strobe
  input wire logic reg_rd_in, // Register read strobe
  input wire logic [7:0] reg_addr_in, // Byte offset
  input wire logic [31:0] reg_wdata_in, // Write data
  output logic [31:0] reg_rdata_out, // Read data
  output logic reg_ack_out, // Access answered
  input wire logic overrun_in, // Periodic list late at frame end
  input wire logic frame_num_wr_in, // Frame number written to memory
  input wire logic frame_bit15_in, // Frame number counter bit 15
  input wire logic sof_in, // Start-of-frame token issued
  input wire logic done_wr_in, // Done head written to memory
  input wire logic fatal_err_in, // Non-USB system error
  input wire logic resume_pin_in, // Downstream resume signalling
  input wire logic sw_resume_in, // Software chose resume state
  input wire logic hub_change_in, // Hub or port status word changed
  input wire logic bulk_start_in, // Engine at bulk list head
  input wire logic bulk_td_in, // Bulk descriptor found
  input wire logic ctrl_start_in, // Engine at control list head
  input wire logic ctrl_td_in, // Control descriptor found
  input wire logic own_done_in, // Ownership changeover complete
  output logic bulk_go_out, // Process bulk list
  output logic ctrl_go_out, // Process control list
  output logic done_hold_out, // Hold further done head writes
  output logic halt_out, // Stop processing and signalling
  output logic sw_reset_out, // Software reset in progress
  output logic [1:0] func_state_out, // Functional state override
  output logic func_state_ld_out, // Load functional state
  output logic irq_out, // Host bus interrupt, level
  output logic system_mgmt_irq_pin_out // Management interrupt, level
);
  import ohci_cmd_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ohci_evt_if evt ();
  logic own_req_ff, bulk_pend_ff, ctrl_pend_ff, rst_cmd_ff;
  logic [1:0] ovr_cnt_ff;
  logic [31:0] enable_ff;
  logic [15:0] rst_cnt_ff;
  logic bit15_ff, fatal_ff;
  logic [2:0] res_sync_ff, hub_sync_ff;
  logic res_seen_ff, hub_seen_ff;
  logic ovr_pend_ff;
  logic [31:0] set_v, clr_v;
  logic wr_ok, rd_ok, rst_done;
  logic wr_cmd, wr_flags, wr_set, wr_clr;

  assign wr_ok = reg_wr_in & ~rst_cmd_ff;
  assign rd_ok = reg_rd_in & ~rst_cmd_ff;
  assign wr_cmd = wr_ok && reg_addr_in == CMD_OFS;
  assign wr_flags = wr_ok && reg_addr_in == FLAGS_OFS;
  assign wr_set = wr_ok && reg_addr_in == EN_SET_OFS;
  assign wr_clr = wr_ok && reg_addr_in == EN_CLR_OFS;
  assign rst_done = rst_cmd_ff && rst_cnt_ff == 16'(RESET_CYCLES - 1);

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      res_sync_ff <= 3'h0;
      hub_sync_ff <= 3'h0;
      res_seen_ff <= 1'b0;
      hub_seen_ff <= 1'b0;
    end else begin
      res_sync_ff <= {res_sync_ff[1:0], resume_pin_in};
      hub_sync_ff <= {hub_sync_ff[1:0], hub_change_in};
      if (res_sync_ff[2] == res_sync_ff[1]) begin
        res_seen_ff <= res_sync_ff[2];
      end
      if (hub_sync_ff[2] == hub_sync_ff[1]) begin
        hub_seen_ff <= hub_sync_ff[2];
      end
    end
  end

  // Frame counter MSB tracking, sampled on each frame number write
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit15_ff <= 1'b0;
      ovr_pend_ff <= 1'b0;
    end else begin
      if (frame_num_wr_in) begin
        bit15_ff <= frame_bit15_in;
      end
      // Overrun flag waits for the frame number update
      if (frame_num_wr_in) begin
        ovr_pend_ff <= 1'b0;
      end else if (overrun_in) begin
        ovr_pend_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flag set and clear masks
  // ----------------------------------------------------------------
  always_comb begin
    set_v = 32'h0;
    set_v[EV_OVERRUN] = frame_num_wr_in & (ovr_pend_ff | overrun_in);
    set_v[EV_DONE] = done_wr_in & ~evt.flags[EV_DONE];
    set_v[EV_SOF] = sof_in;
    set_v[EV_RESUME] = res_sync_ff[2] & res_sync_ff[1] & ~res_seen_ff
      & ~sw_resume_in;
    set_v[EV_FATAL] = fatal_err_in;
    set_v[EV_ROLL] = frame_num_wr_in & (frame_bit15_in ^ bit15_ff);
    set_v[EV_HUB] = hub_sync_ff[2] & hub_sync_ff[1] & ~hub_seen_ff;
    set_v[EV_OWN] = HAS_SMI_PIN & wr_cmd & reg_wdata_in[CMD_OWN_BIT];
    clr_v = wr_flags ? reg_wdata_in : 32'h0;
  end
  assign evt.set_mask = set_v;
  assign evt.clr_mask = clr_v;

  ohci_evt_flags u_flags (
    .clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .evt(evt)
  );

  // ----------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_cmd_ff <= 1'b0;
      rst_cnt_ff <= 16'h0;
    end else if (rst_cmd_ff) begin
      rst_cnt_ff <= rst_cnt_ff + 16'h1;
      if (rst_done) begin
        rst_cmd_ff <= 1'b0;
        rst_cnt_ff <= 16'h0;
      end
    end else if (wr_cmd && reg_wdata_in[CMD_RESET_BIT]) begin
      rst_cmd_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      own_req_ff <= 1'b0;
    end else if (rst_cmd_ff) begin
      own_req_ff <= 1'b0;
    end else if (wr_cmd && reg_wdata_in[CMD_OWN_BIT]) begin
      own_req_ff <= 1'b1;
    end else if (own_done_in) begin
      own_req_ff <= 1'b0;
    end
  end

  // Software write wins over engine clear so a new descriptor is not lost
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bulk_pend_ff <= 1'b0;
      bulk_go_out <= 1'b0;
    end else if (rst_cmd_ff) begin
      bulk_pend_ff <= 1'b0;
      bulk_go_out <= 1'b0;
    end else begin
      if (bulk_start_in) begin
        bulk_go_out <= bulk_pend_ff;
      end
      if ((wr_cmd && reg_wdata_in[CMD_BULK_BIT]) || bulk_td_in) begin
        bulk_pend_ff <= 1'b1;
      end else if (bulk_start_in) begin
        bulk_pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_pend_ff <= 1'b0;
      ctrl_go_out <= 1'b0;
    end else if (rst_cmd_ff) begin
      ctrl_pend_ff <= 1'b0;
      ctrl_go_out <= 1'b0;
    end else begin
      if (ctrl_start_in) begin
        ctrl_go_out <= ctrl_pend_ff;
      end
      if ((wr_cmd && reg_wdata_in[CMD_CTRL_BIT]) || ctrl_td_in) begin
        ctrl_pend_ff <= 1'b1;
      end else if (ctrl_start_in) begin
        ctrl_pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ovr_cnt_ff <= 2'h0;
    end else if (overrun_in) begin
      ovr_cnt_ff <= ovr_cnt_ff + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Enable register with set and clear ports
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      enable_ff <= REG_RESET;
    end else if (rst_cmd_ff) begin
      enable_ff <= REG_RESET;
    end else if (wr_set) begin
      enable_ff <= (enable_ff | reg_wdata_in) & EV_MASK;
    end else if (wr_clr) begin
      enable_ff <= enable_ff & ~reg_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_out <= 1'b0;
      system_mgmt_irq_pin_out <= 1'b0;
      done_hold_out <= 1'b0;
      fatal_ff <= 1'b0;
      halt_out <= 1'b0;
      sw_reset_out <= 1'b0;
      func_state_out <= 2'h0;
      func_state_ld_out <= 1'b0;
    end else begin
      irq_out <= enable_ff[EV_MASTER]
        & |(evt.flags[6:0] & enable_ff[6:0]);
      system_mgmt_irq_pin_out <= HAS_SMI_PIN & enable_ff[EV_MASTER]
        & evt.flags[EV_OWN] & enable_ff[EV_OWN];
      done_hold_out <= evt.flags[EV_DONE] | done_wr_in;
      if (fatal_err_in) begin
        fatal_ff <= 1'b1;
      end else if (rst_cmd_ff) begin
        fatal_ff <= 1'b0;
      end
      halt_out <= fatal_ff | fatal_err_in;
      // Root hub and downstream ports see no reset from this path
      sw_reset_out <= rst_cmd_ff;
      func_state_out <= rst_cmd_ff ? SUSPENDED_STATE : 2'h0;
      func_state_ld_out <= rst_cmd_ff;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= REG_RESET;
      reg_ack_out <= 1'b0;
    end else begin
      reg_ack_out <= rd_ok | wr_ok;
      reg_rdata_out <= 32'h0;
      if (rd_ok) begin
        case (reg_addr_in)
          CMD_OFS: begin
            reg_rdata_out <= {14'h0, ovr_cnt_ff, 12'h0, own_req_ff,
              bulk_pend_ff, ctrl_pend_ff, rst_cmd_ff};
          end
          FLAGS_OFS: begin
            reg_rdata_out <= evt.flags;
          end
          EN_SET_OFS, EN_CLR_OFS: begin
            reg_rdata_out <= enable_ff;
          end
          default: begin
            reg_rdata_out <= 32'h0;
          end
        endcase
      end
    end
  end
endmodule

// ===== verilog/ohci_cmd_pkg.sv
// Purpose: Shared constants for the command and event-flag register block
// Assumes: 32-bit register port, 100 MHz controller clock
// Notes: Offsets are byte offsets within the operational window
package ohci_cmd_pkg;
  localparam logic [7:0] CMD_OFS = 8'h08;
  localparam logic [7:0] FLAGS_OFS = 8'h0C;
  localparam logic [7:0] EN_SET_OFS = 8'h10;
  localparam logic [7:0] EN_CLR_OFS = 8'h14;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  // Command register fields
  localparam int CMD_RESET_BIT = 0;
  localparam int CMD_CTRL_BIT = 1;
  localparam int CMD_BULK_BIT = 2;
  localparam int CMD_OWN_BIT = 3;
  localparam int CMD_CNT_LSB = 16;
  // Event flag fields
  localparam int EV_OVERRUN = 0;
  localparam int EV_DONE = 1;
  localparam int EV_SOF = 2;
  localparam int EV_RESUME = 3;
  localparam int EV_FATAL = 4;
  localparam int EV_ROLL = 5;
  localparam int EV_HUB = 6;
  localparam int EV_OWN = 30;
  localparam int EV_MASTER = 31;
  localparam logic [31:0] EV_MASK = 32'hC000007F;
  localparam logic [31:0] REG_RESET = 32'h00000000;
  localparam logic [1:0] SUSPENDED_STATE = 2'h3;
  // Software reset completion time
  localparam int RESET_TIME_NS = 10000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_CYCLES = RESET_TIME_NS / CLK_PERIOD_NS;
endpackage

// ===== verilog/ohci_evt_flags.sv
// Purpose: Sticky event flags, set by hardware, cleared by writing one
// Assumes: Single clock domain
// Notes: A set in the same cycle as a clear wins
`timescale 1ns/10ps
module ohci_evt_flags (
  input wire logic clk_in, // Clock
  input wire logic rstn_in, // Async reset, low
  ohci_evt_if.dst evt // Set and clear masks
);
  import ohci_cmd_pkg::*;
  logic [31:0] flags_ff;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags_ff <= REG_RESET;
    end else begin
      flags_ff <= ((flags_ff & ~evt.clr_mask) | evt.set_mask) & EV_MASK;
    end
  end
  assign evt.flags = flags_ff;
endmodule

// ===== verilog/ohci_evt_if.sv
// Purpose: Carrier for event strobes toward the flag register
// Assumes: Single clock domain
// Notes: Strobes are one-cycle pulses
`timescale 1ns/10ps
interface ohci_evt_if;
  logic [31:0] set_mask;
  logic [31:0] clr_mask;
  logic [31:0] flags;
  modport src (output set_mask, output clr_mask, input flags);
  modport dst (input set_mask, input clr_mask, output flags);
endinterface
